// File: hw/asc_mute.sv
// Soft mute gain ramp
module asc_mute (
  input  wire logic                       sys_clk,   // System clock
  input  wire logic                       rst,       // Async reset
  input  wire logic                       mute_in,   // Synced mute request
  input  wire logic                       step,      // Ramp step pulse
  output logic [asc_pkg::GAIN_W-1:0]      gain       // Current gain
);
  logic [asc_pkg::GAIN_W-1:0] gain_r;

  // Walk gain one step per sample toward zero or full scale
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gain_r <= '0;
    end else if (step) begin
      if (mute_in && gain_r != '0) begin
        gain_r <= gain_r - asc_pkg::GAIN_STEP;      // [R6]
      end else if (!mute_in && gain_r != asc_pkg::GAIN_MAX) begin
        gain_r <= gain_r + asc_pkg::GAIN_STEP;      // [R6]
      end
    end
  end

  assign gain = gain_r;
endmodule // asc_mute

// File: hw/asc_pkg.sv
// Function
// [R1] Servo measures sample instant difference finely
// [R2] Reset or rate change enters fast settling
// [R3] Settled fast mode switches to slow refine
// [R4] Servo filters jitter with slow loop
// [R5] Mute request high during fast settling
// [R6] Soft mute ramps output down and up
// [R7] System ties mute request to mute input
// [R8] Write pointer offset 16 short, 64 long
// [R9] Ratio measured, filter lengthened when decimating
// [R10] Ratio measurement uses hysteresis
// [R11] Master sends ratio; slaves use it
// [R12] Bypass passes input data straight through
// [R13] Group delay select high means short
// [R14] Bypass input is active high
// [R15] Device reset is active low
// [R16] Chain data input tied low unused
// [R17] Mute request drops on entering slow mode
package asc_pkg;
  // Data, pointer, phase, ratio and counter widths
  localparam int DATA_W  = 24;
  localparam int PTR_W   = 7;
  localparam int PHASE_W = 20;
  localparam int RATIO_W = 8;
  localparam int CNT_W   = 16;
  // Write pointer offsets
  localparam logic [PTR_W-1:0] OFFS_SHORT = 7'h10;
  localparam logic [PTR_W-1:0] OFFS_LONG  = 7'h40;
  // Servo loop gains as right shifts
  localparam int FAST_SHIFT = 2;
  localparam int SLOW_SHIFT = 8;
  // Error band counted as settled; only FAST_BAND is checked, in fast mode, SLOW_BAND is unused
  localparam logic [PHASE_W-1:0] FAST_BAND = 20'h00100;
  localparam logic [PHASE_W-1:0] SLOW_BAND = 20'h00001;
  // Consecutive in-band periods needed to leave fast mode
  localparam logic [7:0] SETTLE_CNT = 8'h10;
  // Ratio hysteresis in fractional steps
  localparam logic [CNT_W-1:0] HYST = 16'h0040;
  // Soft mute gain range and step
  localparam int GAIN_W = 10;
  localparam logic [GAIN_W-1:0] GAIN_MAX  = 10'h3FF;
  localparam logic [GAIN_W-1:0] GAIN_STEP = 10'h001;
  // Reset values
  localparam logic [RATIO_W-1:0] RATIO_RST = 8'h10;
  typedef enum logic [1:0] {
    SRV_IDLE,
    SRV_FAST,
    SRV_SLOW
  } asc_servo_type;
endpackage

// File: hw/asc_ratio.sv
// Measures input samples per output period with hysteresis
module asc_ratio (
  input  wire logic                        sys_clk,     // System clock
  input  wire logic                        rst,         // Async reset
  input  wire logic                        in_tick,     // Input sample pulse
  input  wire logic                        restart,     // Rate change, restart window
  input  wire logic                        out_tick,    // Output sample pulse
  output logic [asc_pkg::RATIO_W-1:0]      ratio_q      // Ratio, 4.4 fixed
);
  logic [asc_pkg::CNT_W-1:0] in_cnt_r;
  logic [asc_pkg::CNT_W-1:0] win_cnt_r;
  logic [asc_pkg::CNT_W-1:0] meas_r;
  logic [7:0]                per_r;
  logic [asc_pkg::CNT_W:0]   rnd;

  // Count input ticks over 256 output periods for eight fractional bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_cnt_r <= '0;
      per_r    <= '0;
      meas_r   <= '0;
    end else if (restart) begin
      // A mixed-rate window could stick behind the hysteresis band
      in_cnt_r <= '0;
      per_r    <= '0;
    end else begin
      if (out_tick) begin
        per_r <= per_r + 8'h01;
        if (per_r == 8'hFF) begin
          meas_r   <= in_cnt_r + {15'h0, in_tick};  // [R9]
          in_cnt_r <= '0;
        end else begin
          in_cnt_r <= in_cnt_r + {15'h0, in_tick};
        end
      end else begin
        in_cnt_r <= in_cnt_r + {15'h0, in_tick};
      end
    end
  end

  // Only move the held ratio when the measurement leaves a hysteresis band
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      win_cnt_r <= {8'h00, asc_pkg::RATIO_RST} << 4;
    end else if ((meas_r > win_cnt_r + asc_pkg::HYST) ||
                 (meas_r + asc_pkg::HYST < win_cnt_r)) begin
      win_cnt_r <= meas_r;                          // [R10]
    end
  end

  // Held value rounded to 4.4 form, saturated
  assign rnd     = {1'b0, win_cnt_r} + 17'h00008;
  assign ratio_q = (rnd[16:12] != 5'h00) ? 8'hFF : rnd[11:4];
endmodule // asc_ratio

// File: hw/asc_top.sv
// Servo, mute, delay, ratio and bypass control of the rate converter
module asc_top (
  input  wire logic                        sys_clk,            // 25 MHz system clock
  input  wire logic                        rst,                // Async reset, high
  input  wire logic                        reset_n,            // Device reset pin, low
  input  wire logic                        fs_in_pin,          // Input sample clock pin
  input  wire logic                        fs_out_pin,         // Output sample clock pin
  input  wire logic                        mute_in,            // Soft mute request pin
  input  wire logic                        group_delay_select, // High short, low long
  input  wire logic                        bypass,             // Bypass pin, high
  input  wire logic                        phase_master,       // Ratio master select
  input  wire logic                        phase_slave,        // Use chain ratio
  input  wire logic                        chain_in,           // Chain serial ratio in
  input  wire logic [asc_pkg::DATA_W-1:0]  in_data,            // Input sample
  input  wire logic                        in_valid,           // Input sample strobe
  output logic [asc_pkg::DATA_W-1:0]       out_data,           // Output sample
  output logic                             out_valid,          // Output strobe
  output logic                             mute_out,           // Settling mute request
  output logic                             chain_out,          // Chain serial ratio out
  output logic [asc_pkg::PTR_W-1:0]        wr_ptr,             // FIFO write pointer
  output logic [asc_pkg::PTR_W-1:0]        rd_ptr,             // FIFO read start
  output logic [asc_pkg::PHASE_W-1:0]      phase_sel,          // Polyphase select
  output logic [asc_pkg::RATIO_W-1:0]      ratio,              // Ratio in use
  output logic [asc_pkg::RATIO_W-1:0]      conv_len,           // Convolution length
  output logic [asc_pkg::GAIN_W-1:0]       gain                // Mute gain
);
  // Pin synchronisers
  logic [1:0] rn_s;
  logic [1:0] fi_s;
  logic [1:0] fo_s;
  logic [1:0] mi_s;
  logic [1:0] gd_s;
  logic [1:0] bp_s;
  logic [1:0] ch_s;
  logic [1:0] pm_s;
  logic [1:0] ps_s;
  logic       fi_d_r;
  logic       fo_d_r;
  logic       in_tick;
  logic       out_tick;
  logic       run;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rn_s <= '0;
      fi_s <= '0;
      fo_s <= '0;
      mi_s <= '0;
      gd_s <= '0;
      bp_s <= '0;
      ch_s <= '0;
      pm_s <= '0;
      ps_s <= '0;
    end else begin
      rn_s <= {rn_s[0], reset_n};
      fi_s <= {fi_s[0], fs_in_pin};
      fo_s <= {fo_s[0], fs_out_pin};
      mi_s <= {mi_s[0], mute_in};
      gd_s <= {gd_s[0], group_delay_select};
      bp_s <= {bp_s[0], bypass};
      ch_s <= {ch_s[0], chain_in};
      pm_s <= {pm_s[0], phase_master};
      ps_s <= {ps_s[0], phase_slave};
    end
  end

  // Rising edge detect on synced sample clocks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fi_d_r <= 1'b0;
      fo_d_r <= 1'b0;
    end else begin
      fi_d_r <= fi_s[1];
      fo_d_r <= fo_s[1];
    end
  end

  assign in_tick  = fi_s[1] & ~fi_d_r;
  assign out_tick = fo_s[1] & ~fo_d_r;
  assign run      = rn_s[1];                        // [R15]

  // Period measurement on both sample clocks
  logic [asc_pkg::CNT_W-1:0] in_per_cnt_r;
  logic [asc_pkg::CNT_W-1:0] out_per_cnt_r;
  logic [asc_pkg::CNT_W-1:0] in_per_r;
  logic [asc_pkg::CNT_W-1:0] out_per_r;
  logic                      rate_chg_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_per_cnt_r  <= '0;
      out_per_cnt_r <= '0;
      in_per_r      <= '0;
      out_per_r     <= '0;
      rate_chg_r    <= 1'b0;
    end else begin
      in_per_cnt_r  <= in_tick ? '0 : in_per_cnt_r + 16'h0001;
      out_per_cnt_r <= out_tick ? '0 : out_per_cnt_r + 16'h0001;
      rate_chg_r    <= 1'b0;
      if (in_tick) begin
        in_per_r <= in_per_cnt_r;
        // A jump of more than 1/8 period counts as a new rate
        if ((in_per_cnt_r > in_per_r + (in_per_r >> 3)) ||
            (in_per_cnt_r + (in_per_r >> 3) < in_per_r)) begin
          rate_chg_r <= 1'b1;                       // [R2]
        end
      end
      if (out_tick) begin
        out_per_r <= out_per_cnt_r;
        if ((out_per_cnt_r > out_per_r + (out_per_r >> 3)) ||
            (out_per_cnt_r + (out_per_r >> 3) < out_per_r)) begin
          rate_chg_r <= 1'b1;                       // [R2]
        end
      end
    end
  end

  // Phase ramp advanced by input samples, sampled at every sixteenth output instant
  logic [asc_pkg::PHASE_W-1:0] ramp_r;
  logic [asc_pkg::PHASE_W-1:0] est_r;
  logic [asc_pkg::PHASE_W-1:0] err;
  logic [asc_pkg::PHASE_W-1:0] err_abs;
  logic [asc_pkg::PHASE_W-1:0] corr;
  logic [7:0]                  settle_r;
  asc_pkg::asc_servo_type      state_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ramp_r <= '0;
    end else if (in_tick) begin
      ramp_r <= ramp_r + 20'h01000;                 // [R1]
    end else if (in_per_r != '0) begin
      ramp_r <= ramp_r + 20'h00001;                 // [R1]
    end
  end

  // Ramp advance over sixteen output periods averages out tick quantisation
  logic [3:0]                  win_r;
  logic [asc_pkg::PHASE_W-1:0] ramp_at_r;
  logic                        upd;

  assign upd = out_tick & (win_r == 4'hF);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      win_r     <= '0;
      ramp_at_r <= '0;
    end else if (out_tick) begin
      win_r <= win_r + 4'h1;
      if (win_r == 4'hF) begin
        ramp_at_r <= ramp_r;
      end
    end
  end

  // Error between measured advance and estimate, fine-grained phase units
  assign err     = (ramp_r - ramp_at_r) - est_r;    // [R1]
  assign err_abs = err[asc_pkg::PHASE_W-1] ? (~err + 20'h00001) : err;
  // Gain set by mode; low slow gain gives the sub-hertz jitter filter
  assign corr    = (state_r == asc_pkg::SRV_FAST) ?
                   {{asc_pkg::FAST_SHIFT{err[19]}}, err[19:asc_pkg::FAST_SHIFT]} :
                   {{asc_pkg::SLOW_SHIFT{err[19]}}, err[19:asc_pkg::SLOW_SHIFT]}; // [R4]

  // Servo estimate update once per sixteen output samples
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      est_r <= '0;
    end else if (!run) begin
      est_r <= '0;
    end else if (upd) begin
      est_r <= est_r + corr;                        // [R4]
    end
  end

  // Settling mode sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r  <= asc_pkg::SRV_IDLE;
      settle_r <= '0;
    end else if (!run) begin
      state_r  <= asc_pkg::SRV_IDLE;
      settle_r <= '0;
    end else begin
      case (state_r)
        asc_pkg::SRV_IDLE: begin
          state_r  <= asc_pkg::SRV_FAST;            // [R2]
          settle_r <= '0;
        end
        asc_pkg::SRV_FAST: begin
          if (upd) begin
            if (err_abs > asc_pkg::FAST_BAND) begin
              settle_r <= '0;
            end else if (settle_r == asc_pkg::SETTLE_CNT) begin
              state_r  <= asc_pkg::SRV_SLOW;        // [R3]
            end else begin
              settle_r <= settle_r + 8'h01;
            end
          end
        end
        asc_pkg::SRV_SLOW: begin
          settle_r <= '0;
          if (rate_chg_r) begin
            state_r <= asc_pkg::SRV_FAST;           // [R2]
          end
        end
        default: begin
          state_r <= asc_pkg::SRV_IDLE;
        end
      endcase
    end
  end

  // Mute request follows fast settling; idle also mutes
  assign mute_out = (state_r != asc_pkg::SRV_SLOW); // [R5] [R17]
  // Fine phase chooses polyphase coefficient set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_sel <= '0;
    end else if (out_tick) begin
      phase_sel <= est_r;                           // [R1] [R3]
    end
  end

  // Write pointer with group delay offset, read start follows servo
  logic [asc_pkg::PTR_W-1:0] wcnt_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wcnt_r <= '0;
      wr_ptr <= '0;
    end else begin
      if (in_tick) begin
        wcnt_r <= wcnt_r + 7'h01;
      end
      wr_ptr <= wcnt_r + (gd_s[1] ? asc_pkg::OFFS_SHORT : asc_pkg::OFFS_LONG); // [R8] [R13]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_ptr <= '0;
    end else if (out_tick) begin
      rd_ptr <= est_r[18:12];
    end
  end

  // Ratio measurement, shared over chain
  logic [asc_pkg::RATIO_W-1:0] local_ratio;
  logic [asc_pkg::RATIO_W-1:0] tx_sh_r;
  logic [asc_pkg::RATIO_W-1:0] rx_sh_r;
  logic [asc_pkg::RATIO_W-1:0] rx_ratio_r;
  logic [2:0]                  bit_r;

  asc_ratio u_ratio (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .in_tick  (in_tick),
    .restart  (rate_chg_r),
    .out_tick (out_tick),
    .ratio_q  (local_ratio)
  );

  // Serial ratio frame, one bit per output sample, MSB first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_r      <= '0;
      tx_sh_r    <= '0;
      rx_sh_r    <= '0;
      rx_ratio_r <= asc_pkg::RATIO_RST;
      chain_out  <= 1'b0;
    end else if (out_tick) begin
      bit_r   <= bit_r + 3'h1;
      rx_sh_r <= {rx_sh_r[6:0], ch_s[1]};           // [R16]
      if (bit_r == 3'h7) begin
        tx_sh_r    <= local_ratio;
        rx_ratio_r <= {rx_sh_r[6:0], ch_s[1]};      // [R11]
      end else begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
      chain_out <= pm_s[1] & tx_sh_r[7];            // [R11]
    end else if (!pm_s[1]) begin
      chain_out <= 1'b0;                            // [R11]
    end
  end

  // Slaves adopt the master ratio
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ratio    <= asc_pkg::RATIO_RST;
      conv_len <= asc_pkg::RATIO_RST;
    end else begin
      ratio    <= ps_s[1] ? rx_ratio_r : local_ratio; // [R11]
      // Lengthen convolution only when decimating (ratio above 1.0)
      conv_len <= (ratio > asc_pkg::RATIO_RST) ? ratio : asc_pkg::RATIO_RST; // [R9]
    end
  end

  // Soft mute ramp
  asc_mute u_mute (
    .sys_clk (sys_clk),
    .rst     (rst),
    .mute_in (mi_s[1]),
    .step    (out_tick),
    .gain    (gain)
  );

  // Data path: bypass passes input unscaled, else gain-scaled
  logic [asc_pkg::DATA_W+asc_pkg::GAIN_W-1:0] prod;
  assign prod = $signed(in_data) * $signed({1'b0, gain});

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (bp_s[1]) begin
        out_data <= in_data;                        // [R12] [R14]
      end else if (in_valid) begin
        out_data <= prod[asc_pkg::DATA_W+asc_pkg::GAIN_W-1:asc_pkg::GAIN_W]; // [R6]
      end
    end
  end
endmodule // asc_top

// File: verification/asc_chk.sv
// Port-level checks of the converter control
module asc_chk (
  input wire logic                        sys_clk,            // Clock
  input wire logic                        rst,                // Reset
  input wire logic                        reset_n,            // Device reset
  input wire logic                        fs_in_pin,          // Input rate
  input wire logic                        fs_out_pin,         // Output rate
  input wire logic                        mute_in,            // Soft mute
  input wire logic                        group_delay_select, // Delay select
  input wire logic                        bypass,             // Bypass
  input wire logic                        phase_master,       // Ratio master
  input wire logic [asc_pkg::DATA_W-1:0]  in_data,            // Input sample
  input wire logic                        in_valid,           // Input strobe
  input wire logic [asc_pkg::DATA_W-1:0]  out_data,           // Output sample
  input wire logic                        out_valid,          // Output strobe
  input wire logic                        mute_out,           // Settling mute
  input wire logic                        chain_out,          // Chain out
  input wire logic [asc_pkg::PTR_W-1:0]   wr_ptr,             // Write pointer
  input wire logic [asc_pkg::RATIO_W-1:0] ratio,              // Ratio
  input wire logic [asc_pkg::RATIO_W-1:0] conv_len,           // Conv length
  input wire logic [asc_pkg::GAIN_W-1:0]  gain                // Gain
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] ot_r;
  logic [3:0] q_r;
  logic [3:0] ms_r;
  logic [3:0] bs_r;
  // Settle ticks, quiet span and input steadiness counters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ot_r <= 8'h00;
      q_r <= 4'h0;
      ms_r <= 4'h0;
      bs_r <= 4'h0;
    end else begin
      ot_r <= !mute_out ? 8'h00 : ot_r + {7'h00, fs_out_pin && !$past(fs_out_pin) && ot_r != 8'hFF};
      q_r <= ($changed(fs_in_pin) || $changed(group_delay_select) || in_valid) ? 4'h0 :
             q_r + {3'h0, q_r != 4'hF};
      ms_r <= $changed(mute_in) ? 4'h0 : ms_r + {3'h0, ms_r != 4'hF};
      bs_r <= $changed(bypass) ? 4'h0 : bs_r + {3'h0, bs_r != 4'hF};
    end
  end
  valid_delay_a: assert property (in_valid |=> out_valid)
    else $error("out_valid missing after in_valid");
  bypass_data_a: assert property (bs_r >= 4'h5 && bypass && in_valid |=> out_data == $past(in_data))
    else $error("bypass data mismatch");
  reset_mute_a: assert property (!reset_n && !$past(reset_n) && !$past(reset_n, 2) && !$past(reset_n, 3) |-> mute_out)
    else $error("mute_out low in device reset");
  settle_count_a: assert property ($fell(mute_out) |-> ot_r >= 8'h11)
    else $error("fast mode left too early");
  ptr_still_a: assert property (q_r >= 4'h8 |-> $stable(wr_ptr))
    else $error("wr_ptr moved without cause");
  gain_step_a: assert property ($changed(gain) |-> gain == $past(gain) + asc_pkg::GAIN_STEP || gain == $past(gain) - asc_pkg::GAIN_STEP)
    else $error("gain jumped");
  gain_down_a: assert property (ms_r >= 4'h5 && mute_in && $changed(gain) |-> gain < $past(gain))
    else $error("gain rose while muted");
  gain_up_a: assert property (ms_r >= 4'h5 && !mute_in && $changed(gain) |-> gain > $past(gain))
    else $error("gain fell while unmuted");
  conv_len_a: assert property (conv_len == (($past(ratio) > 8'h10) ? $past(ratio) : 8'h10))
    else $error("conv_len not max of ratio and one");
  chain_quiet_a: assert property (!phase_master && !$past(phase_master) && !$past(phase_master, 2) && !$past(phase_master, 3) |-> !chain_out)
    else $error("chain_out active without master");
endmodule // asc_chk
bind asc_top asc_chk i_chk (.*);

// File: verification/asc_far_end.sv
// Serial source, sink clock and peer converter seen from the block
module asc_far_end (
  input  wire logic                  sys_clk,    // System clock
  input  wire logic                  run,        // Sample clocks running
  input  wire logic [7:0]            in_half,    // Input half period, cycles
  input  wire logic [7:0]            out_half,   // Output half period, cycles
  input  wire logic                  peer_en,    // Peer sends ratio frames
  input  wire logic [7:0]            peer_ratio, // Peer ratio byte
  output logic                       fs_in_pin,  // Input sample clock
  output logic                       fs_out_pin, // Output sample clock
  output logic [asc_pkg::DATA_W-1:0] in_data,    // Source sample
  output logic                       in_valid,   // Source strobe
  output logic                       chain_in    // Peer serial ratio
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  ci_r = 8'h00;
  logic [7:0]  co_r = 8'h00;
  logic [2:0]  bit_r = 3'h7;
  logic [23:0] smp_r = 24'h7FF001;
  initial fs_in_pin = 1'b0;
  initial fs_out_pin = 1'b0;
  initial in_valid = 1'b0;
  initial in_data = 24'h000000;
  initial chain_in = 1'b0;
  // Input clock, one sample per rise; data inverted when not qualified
  always @(negedge sys_clk) begin
    in_valid <= 1'b0;
    in_data <= ~smp_r;
    ci_r <= ci_r + 8'h01;
    if (!run) begin
      fs_in_pin <= 1'b0;
    end else if (ci_r + 8'h01 >= in_half) begin
      ci_r <= 8'h00;
      fs_in_pin <= !fs_in_pin;
      if (!fs_in_pin) begin
        in_valid <= 1'b1;
        in_data <= smp_r;
        smp_r <= smp_r + 24'h0A3B5D;
      end
    end
  end
  // Output clock; peer shifts its ratio MSB first, else chain held low
  always @(negedge sys_clk) begin
    co_r <= co_r + 8'h01;
    if (!run) begin
      fs_out_pin <= 1'b0;
    end else if (co_r + 8'h01 >= out_half) begin
      co_r <= 8'h00;
      fs_out_pin <= !fs_out_pin;
      if (!fs_out_pin) begin
        chain_in <= peer_en ? peer_ratio[bit_r] : 1'b0;
        bit_r <= bit_r - 3'h1;
      end
    end
  end
endmodule // asc_far_end

// File: verification/tb.sv
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < n) begin @(negedge sys_clk); k++; end end
// Bench top: drives the control pins, runs the far end, checks results
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, reset_n, sel, byp, pm, ps, run, peer_en, follow, force_m;
  logic fs_in_pin, fs_out_pin, chain_in, in_valid, out_valid, mute_out, mute_in;
  logic [7:0]  in_half, out_half, ratio, conv_len;
  logic [23:0] in_data, out_data;
  logic [6:0]  wr_ptr, pa;
  logic [9:0]  gain;
  int n_errors = 0;
  int n_compared = 0;
  int k;
  assign mute_in = follow ? mute_out : force_m;
  asc_top i_dut (.sys_clk(sys_clk), .rst(rst), .reset_n(reset_n), .fs_in_pin(fs_in_pin),
    .fs_out_pin(fs_out_pin), .mute_in(mute_in), .group_delay_select(sel), .bypass(byp),
    .phase_master(pm), .phase_slave(ps), .chain_in(chain_in), .in_data(in_data),
    .in_valid(in_valid), .out_data(out_data), .out_valid(out_valid), .mute_out(mute_out),
    .chain_out(), .wr_ptr(wr_ptr), .rd_ptr(), .phase_sel(), .ratio(ratio),
    .conv_len(conv_len), .gain(gain));
  asc_far_end i_far (.sys_clk(sys_clk), .run(run), .in_half(in_half), .out_half(out_half),
    .peer_en(peer_en), .peer_ratio(8'hFF), .fs_in_pin(fs_in_pin), .fs_out_pin(fs_out_pin),
    .in_data(in_data), .in_valid(in_valid), .chain_in(chain_in));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic final_report();
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One sample through the data path against the scaled or bypassed value
  task automatic check_data(input logic b);
    logic [23:0] d;
    logic signed [34:0] p;
    @(negedge sys_clk);
    #1;
    while (in_valid !== 1'b1) begin
      @(negedge sys_clk);
      #1;
    end
    d = in_data;
    p = $signed(d) * $signed({1'b0, gain});
    @(posedge sys_clk);
    #1;
    `CHK("out_valid", 1'b1, out_valid)
    `CHK("out_data", b ? d : p[33:10], out_data)
    @(negedge sys_clk);
  endtask
  // Watchdog
  initial begin
    repeat (95000) @(posedge sys_clk);
    n_errors++;
    final_report();
  end
  // Scenarios
  initial begin
    {rst, reset_n, sel, byp, pm, ps, run, peer_en, follow, force_m} = 10'b1010000010;
    in_half = 8'h04;
    out_half = 8'h08;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK("mute_out", 1'b1, mute_out)
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    pa = wr_ptr;
    sel = 1'b0;
    repeat (8) @(negedge sys_clk);
    `CHK("wr_ptr", 7'h30, wr_ptr - pa)
    sel = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK("wr_ptr", pa, wr_ptr)
    run = 1'b1;
    `WAITC(mute_out === 1'b0, 20000)
    `CHK("mute_out", 1'b0, mute_out)
    repeat (400) @(negedge sys_clk);
    `CHK("ratio", 8'h20, ratio)
    `CHK("conv_len", 8'h20, conv_len)
    `WAITC(gain === 10'h3FF, 20000)
    `CHK("gain", 10'h3FF, gain)
    check_data(1'b0);
    follow = 1'b0;
    force_m = 1'b1;
    `WAITC(gain === 10'h000, 20000)
    `CHK("gain", 10'h000, gain)
    check_data(1'b0);
    in_half = 8'h08;
    out_half = 8'h04;
    `WAITC(mute_out === 1'b1, 300)
    `CHK("mute_out", 1'b1, mute_out)
    `WAITC(mute_out === 1'b0, 20000)
    `CHK("mute_out", 1'b0, mute_out)
    repeat (400) @(negedge sys_clk);
    `CHK("ratio", 8'h08, ratio)
    `CHK("conv_len", 8'h10, conv_len)
    byp = 1'b1;
    repeat (6) @(negedge sys_clk);
    check_data(1'b1);
    byp = 1'b0;
    peer_en = 1'b1;
    ps = 1'b1;
    repeat (300) @(negedge sys_clk);
    `CHK("ratio", 8'hFF, ratio)
    ps = 1'b0;
    peer_en = 1'b0;
    pm = 1'b1;
    repeat (100) @(negedge sys_clk);
    pm = 1'b0;
    reset_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK("mute_out", 1'b1, mute_out)
    final_report();
  end
endmodule // tb
